// >>> hw/charger_supervision_pkg.sv
// Register map, fields and timing constants of the supervision block.
package charger_supervision_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_CONV_CTRL = 8'h00;
    localparam logic [7:0] ADDR_RESULT_BASE = 8'h01;
    localparam logic [7:0] ADDR_RESULT_LAST = 8'h06;
    localparam logic [7:0] ADDR_DOUBLER_CTRL = 8'h08;
    localparam logic [7:0] ADDR_SAFETY_RELOAD = 8'h09;
    localparam logic [7:0] ADDR_HOST_RELOAD = 8'h0A;
    localparam logic [7:0] ADDR_HOST_VALUE = 8'h0B;
    localparam logic [7:0] ADDR_OC_LIMIT = 8'h0C;
    localparam logic [7:0] ADDR_EVENT = 8'h10;
    localparam logic [7:0] ADDR_MASK = 8'h11;
    localparam logic [7:0] ADDR_STATUS = 8'h12;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int CONV_CONT_BIT = 0;
    localparam int CONV_ONESHOT_BIT = 1;
    localparam int CONV_AVG_LSB = 2;
    localparam int CONV_BUSY_BIT = 4;
    localparam int DBL_EN_BIT = 0;
    localparam int DBL_OC_STOP_BIT = 1;
    localparam int EV_DONE_BIT = 0;
    localparam int EV_SAFETY_BIT = 1;
    localparam int EV_HOST_BIT = 2;
    localparam int EV_OC_BIT = 3;

    // ------------------------------------------------------------------
    // Reset values and sizes
    // ------------------------------------------------------------------
    localparam logic [7:0] CONV_CTRL_RESET = 8'h01;
    localparam logic [3:0] MASK_RESET = 4'hF;
    localparam logic [7:0] SAFETY_RELOAD_RESET = 8'hFF;
    localparam logic [7:0] HOST_RELOAD_RESET = 8'hFF;
    localparam int CHANNELS = 6;
    localparam logic [2:0] LAST_CHANNEL = 3'h5;
    localparam logic [7:0] CODE_BASE = 8'h10;
    localparam logic [7:0] CODE_SPAN = 8'hE0;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLOCK_MHZ = 125;
    localparam int FAULT_MIN_NS = 1000;
    localparam int FAULT_MIN_CYCLES = (FAULT_MIN_NS * CLOCK_MHZ + 999) / 1000;
    localparam int TICK_US = 1000;
    localparam int TICK_CYCLES_DEFAULT = TICK_US * CLOCK_MHZ;
    localparam int SAMPLE_CYCLES = 16;

    typedef enum logic [1:0] {
        CONV_IDLE,
        CONV_SAMPLE,
        CONV_STORE
    } conv_state_t;

    typedef struct packed {
        logic vin_present;
        logic vin_ov;
        logic vin_uv;
        logic vbat_ov;
        logic vbat_uv;
        logic ratio_high;
        logic ratio_low;
        logic crit_temp;
        logic vbat_warn;
    } protect_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

endpackage : charger_supervision_pkg

// >>> hw/charger_supervision_control.sv
// Charger supervision: converter sequencer, timers and control pins.
//
// Overview of operation
// - Eight-bit converter runs only in idle or active.
// - Resets into continuous mode, refreshing every channel.
// - Each result averages the selected conversion count.
// - Continuous mode raises done once per start.
// - One-shot trigger runs one sweep, then done.
// - Six channels sequenced in fixed order one-six.
// - Code sixteen is range bottom, span 224.
// - Safety timer runs whenever device is active.
// - Safety expiry raises event, clears doubler enable.
// - Only reload write resets safety count.
// - Doubler restarts after event clear and re-enable.
// - Protection faults disable the safety timer.
// - Host timer loads reload on enable, counts down.
// - Host timer zero raises event, stops charging.
// - Protection faults disable the host timer.
// - Master power enable gates all internal logic.
// - Pin edges and writes set or clear doubler.
// - Fault output follows faults with minimum width.
// - Level interrupt until events clear; masks set.
// - Events during event read are held, posted later.
// - Over-current compare in continuous, nonzero limit.
`timescale 1ns/1ps
`default_nettype none

module charger_supervision_control
    import charger_supervision_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYCLES_DEFAULT
) (
    input wire logic i_mclk,
    input wire logic i_reset_n,
    input wire logic i_master_power_enable,
    input wire logic i_doubler_enable_pin_n,
    input wire logic i_mode_active,
    input wire logic i_mode_idle,
    input wire protect_t i_protect,
    input wire logic [7:0] i_sample,
    input wire logic i_sample_valid,
    input wire reg_req_t i_req,
    output logic [2:0] o_channel_select,
    output logic o_sample_start,
    output logic [7:0] o_rdata,
    output logic o_doubler_enable,
    output logic o_fault_out_n,
    output logic o_interrupt_out_n
);

    // ------------------------------------------------------------------
    // Input synchronisers and power gating
    // ------------------------------------------------------------------
    logic [1:0] pwr_sync_q;
    logic [1:0] pin_sync_q;
    logic pin_prev_q;
    protect_t prot_meta_q;
    protect_t prot_q;
    logic run;

    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            pwr_sync_q <= 2'h0;
            pin_sync_q <= 2'h3;
            pin_prev_q <= 1'b1;
            prot_meta_q <= '0;
            prot_q <= '0;
        end else begin
            pwr_sync_q <= {pwr_sync_q[0], i_master_power_enable};
            pin_sync_q <= {pin_sync_q[0], i_doubler_enable_pin_n};
            pin_prev_q <= pin_sync_q[1];
            prot_meta_q <= i_protect;
            prot_q <= prot_meta_q;
        end
    end

    assign run = pwr_sync_q[1];

    logic pin_fall;
    logic pin_rise;
    logic protect_fault;
    assign pin_fall = pin_prev_q & ~pin_sync_q[1];
    assign pin_rise = ~pin_prev_q & pin_sync_q[1];
    assign protect_fault = ~prot_q.vin_present | prot_q.vin_ov | prot_q.vin_uv
                         | prot_q.vbat_ov | prot_q.vbat_uv | prot_q.crit_temp;

    // ------------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------------
    logic wr_conv;
    logic wr_dbl;
    logic wr_safety;
    logic wr_host;
    logic wr_event;
    logic rd_event;
    assign wr_conv = run & i_req.wr & (i_req.addr == ADDR_CONV_CTRL);
    assign wr_dbl = run & i_req.wr & (i_req.addr == ADDR_DOUBLER_CTRL);
    assign wr_safety = run & i_req.wr & (i_req.addr == ADDR_SAFETY_RELOAD);
    assign wr_host = run & i_req.wr & (i_req.addr == ADDR_HOST_RELOAD);
    assign wr_event = run & i_req.wr & (i_req.addr == ADDR_EVENT);
    assign rd_event = run & i_req.rd & (i_req.addr == ADDR_EVENT);

    logic cont_q;
    logic [1:0] avg_q;
    logic oc_stop_q;
    logic [7:0] oc_limit_q;
    logic [7:0] safety_reload_q;
    logic [7:0] host_reload_q;
    logic [3:0] mask_q;

    always_ff @(posedge i_mclk) begin
        if (!i_reset_n || !run) begin
            cont_q <= CONV_CTRL_RESET[CONV_CONT_BIT];
            avg_q <= 2'h0;
            oc_stop_q <= 1'b0;
            oc_limit_q <= 8'h00;
            safety_reload_q <= SAFETY_RELOAD_RESET;
            host_reload_q <= HOST_RELOAD_RESET;
            mask_q <= MASK_RESET;
        end else if (i_req.wr) begin
            if (i_req.addr == ADDR_CONV_CTRL) begin
                cont_q <= i_req.wdata[CONV_CONT_BIT];
                avg_q <= i_req.wdata[CONV_AVG_LSB +: 2];
            end else if (i_req.addr == ADDR_DOUBLER_CTRL) begin
                oc_stop_q <= i_req.wdata[DBL_OC_STOP_BIT];
            end else if (i_req.addr == ADDR_OC_LIMIT) begin
                oc_limit_q <= i_req.wdata;
            end else if (i_req.addr == ADDR_SAFETY_RELOAD) begin
                safety_reload_q <= i_req.wdata;
            end else if (i_req.addr == ADDR_HOST_RELOAD) begin
                host_reload_q <= i_req.wdata;
            end else if (i_req.addr == ADDR_MASK) begin
                mask_q <= i_req.wdata[3:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // Converter sequencer
    // ------------------------------------------------------------------
    conv_state_t conv_q;
    logic [2:0] chan_q;
    logic [3:0] nconv_q;
    logic [11:0] acc_q;
    logic [7:0] result_q [CHANNELS];
    logic sweep_end;
    logic first_done_q;
    logic one_shot_q;
    logic conv_allowed;
    logic done_evt;
    logic oc_evt;
    logic start_q;

    function automatic logic [3:0] avg_count(input logic [1:0] sel);
        avg_count = 4'h1 << sel;
    endfunction : avg_count

    assign conv_allowed = run & (i_mode_idle | i_mode_active);
    assign sweep_end = (conv_q == CONV_STORE) && (chan_q == LAST_CHANNEL);

    always_ff @(posedge i_mclk) begin
        if (!i_reset_n || !conv_allowed) begin
            conv_q <= CONV_IDLE;
            chan_q <= 3'h0;
            nconv_q <= 4'h0;
            acc_q <= 12'h000;
            one_shot_q <= 1'b0;
            start_q <= 1'b0;
        end else begin
            start_q <= 1'b0;
            if (wr_conv && !i_req.wdata[CONV_CONT_BIT] && i_req.wdata[CONV_ONESHOT_BIT]) begin
                one_shot_q <= 1'b1;
            end
            case (conv_q)
                CONV_IDLE: begin
                    if (cont_q || one_shot_q) begin
                        conv_q <= CONV_SAMPLE;
                        chan_q <= 3'h0;
                        nconv_q <= 4'h0;
                        acc_q <= 12'h000;
                        start_q <= 1'b1;
                    end
                end
                CONV_SAMPLE: begin
                    if (i_sample_valid) begin
                        acc_q <= acc_q + {4'h0, i_sample};
                        nconv_q <= nconv_q + 4'h1;
                        if (nconv_q + 4'h1 == avg_count(avg_q)) begin
                            conv_q <= CONV_STORE;
                        end else begin
                            start_q <= 1'b1;
                        end
                    end
                end
                CONV_STORE: begin
                    acc_q <= 12'h000;
                    nconv_q <= 4'h0;
                    if (chan_q == LAST_CHANNEL) begin
                        chan_q <= 3'h0;
                        one_shot_q <= 1'b0;
                        conv_q <= cont_q ? CONV_SAMPLE : CONV_IDLE;
                        start_q <= cont_q;
                    end else begin
                        chan_q <= chan_q + 3'h1;
                        conv_q <= CONV_SAMPLE;
                        start_q <= 1'b1;
                    end
                end
                default: conv_q <= CONV_IDLE;
            endcase
        end
    end

    // Results keep the raw code averaged over the selected conversion count.
    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            for (int i = 0; i < CHANNELS; i++) begin
                result_q[i] <= 8'h00;
            end
        end else if (conv_allowed && conv_q == CONV_STORE) begin
            result_q[chan_q] <= 8'(acc_q >> avg_q);
        end
    end

    // Done fires once per continuous start, and after each one-shot sweep.
    always_ff @(posedge i_mclk) begin
        if (!i_reset_n || !conv_allowed || !cont_q) begin
            first_done_q <= 1'b0;
        end else if (sweep_end) begin
            first_done_q <= 1'b1;
        end
    end
    assign done_evt = sweep_end && (cont_q ? !first_done_q : one_shot_q);

    assign oc_evt = (conv_q == CONV_STORE) && (chan_q == 3'h2) && cont_q
                  && (oc_limit_q != 8'h00) && (8'(acc_q >> avg_q) > oc_limit_q);

    // ------------------------------------------------------------------
    // Timers
    // ------------------------------------------------------------------
    logic [31:0] presc_q;
    logic tick;
    logic [7:0] safety_q;
    logic [7:0] host_q;
    logic host_run_q;
    logic safety_evt;
    logic host_evt;
    logic dbl_q;

    always_ff @(posedge i_mclk) begin
        if (!i_reset_n || !run || presc_q == 32'(TICK_CYCLES - 1)) begin
            presc_q <= 32'h0;
        end else begin
            presc_q <= presc_q + 32'h1;
        end
    end
    assign tick = run && presc_q == 32'(TICK_CYCLES - 1);

    // Only a reload write restarts the count.
    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            safety_q <= SAFETY_RELOAD_RESET;
        end else if (wr_safety) begin
            safety_q <= i_req.wdata;
        end else if (tick && i_mode_active && !protect_fault && safety_q != 8'h00) begin
            safety_q <= safety_q - 8'h01;
        end
    end
    assign safety_evt = tick && i_mode_active && !protect_fault && safety_q == 8'h01;

    always_ff @(posedge i_mclk) begin
        if (!i_reset_n || !run || protect_fault) begin
            host_run_q <= 1'b0;
            host_q <= 8'h00;
        end else if (dbl_q && !host_run_q) begin
            host_run_q <= 1'b1;
            host_q <= host_reload_q;
        end else if (!dbl_q) begin
            host_run_q <= 1'b0;
        end else if (wr_host) begin
            host_q <= i_req.wdata;
        end else if (tick && host_q != 8'h00) begin
            host_q <= host_q - 8'h01;
        end
    end
    assign host_evt = host_run_q && tick && host_q == 8'h01 && !wr_host;

    // ------------------------------------------------------------------
    // Events, doubler enable and outputs
    // ------------------------------------------------------------------
    logic [3:0] event_q;
    logic [3:0] pend_q;
    logic [3:0] new_evt;
    logic [3:0] clr;
    assign new_evt = {oc_evt, host_evt, safety_evt, done_evt};
    assign clr = wr_event ? i_req.wdata[3:0] : 4'h0;

    // Events raised during an event read post on the next clear.
    always_ff @(posedge i_mclk) begin
        if (!i_reset_n || !run) begin
            event_q <= 4'h0;
            pend_q <= 4'h0;
        end else if (rd_event) begin
            pend_q <= pend_q | new_evt;
        end else begin
            event_q <= (event_q & ~clr) | new_evt | (wr_event ? pend_q : 4'h0);
            pend_q <= wr_event ? 4'h0 : pend_q;
        end
    end

    // After a safety or host timer trip, enable waits for the event clear.
    always_ff @(posedge i_mclk) begin
        if (!i_reset_n || !run) begin
            dbl_q <= 1'b0;
        end else if (safety_evt || (oc_evt && oc_stop_q) || protect_fault) begin
            dbl_q <= 1'b0;
        end else if (host_evt) begin
            dbl_q <= 1'b0;
        end else if (pin_rise) begin
            dbl_q <= 1'b0;
        end else if ((pin_fall || (wr_dbl && i_req.wdata[DBL_EN_BIT]))
                     && !event_q[EV_SAFETY_BIT] && !event_q[EV_HOST_BIT]) begin
            dbl_q <= 1'b1;
        end else if (wr_dbl && !i_req.wdata[DBL_EN_BIT]) begin
            dbl_q <= 1'b0;
        end
    end

    logic fault_any;
    logic [7:0] fault_cnt_q;
    assign fault_any = prot_q.vin_ov | prot_q.vin_uv | prot_q.vbat_ov | prot_q.vbat_uv
                     | prot_q.ratio_high | prot_q.ratio_low | prot_q.crit_temp
                     | prot_q.vbat_warn | event_q[EV_OC_BIT];

    always_ff @(posedge i_mclk) begin
        if (!i_reset_n || !run) begin
            fault_cnt_q <= 8'h00;
            o_fault_out_n <= 1'b1;
        end else if (fault_any) begin
            fault_cnt_q <= 8'(FAULT_MIN_CYCLES);
            o_fault_out_n <= 1'b0;
        end else if (fault_cnt_q > 8'h01) begin
            fault_cnt_q <= fault_cnt_q - 8'h01;
        end else begin
            fault_cnt_q <= 8'h00;
            o_fault_out_n <= 1'b1;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_reset_n || !run) begin
            o_interrupt_out_n <= 1'b1;
            o_doubler_enable <= 1'b0;
            o_channel_select <= 3'h0;
            o_sample_start <= 1'b0;
        end else begin
            o_interrupt_out_n <= ~|(event_q & ~mask_q);
            o_doubler_enable <= dbl_q;
            o_channel_select <= chan_q;
            o_sample_start <= start_q;
        end
    end

    // ------------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------------
    always_ff @(posedge i_mclk) begin
        if (!i_reset_n || !run || !i_req.rd) begin
            o_rdata <= 8'h00;
        end else if (i_req.addr == ADDR_CONV_CTRL) begin
            o_rdata <= {3'h0, conv_q != CONV_IDLE, avg_q, one_shot_q, cont_q};
        end else if (i_req.addr >= ADDR_RESULT_BASE && i_req.addr <= ADDR_RESULT_LAST) begin
            o_rdata <= result_q[3'(i_req.addr - ADDR_RESULT_BASE)];
        end else if (i_req.addr == ADDR_DOUBLER_CTRL) begin
            o_rdata <= {6'h00, oc_stop_q, dbl_q};
        end else if (i_req.addr == ADDR_SAFETY_RELOAD) begin
            o_rdata <= safety_q;
        end else if (i_req.addr == ADDR_HOST_RELOAD) begin
            o_rdata <= host_reload_q;
        end else if (i_req.addr == ADDR_HOST_VALUE) begin
            o_rdata <= host_q;
        end else if (i_req.addr == ADDR_OC_LIMIT) begin
            o_rdata <= oc_limit_q;
        end else if (i_req.addr == ADDR_EVENT) begin
            o_rdata <= {4'h0, event_q};
        end else if (i_req.addr == ADDR_MASK) begin
            o_rdata <= {4'h0, mask_q};
        end else if (i_req.addr == ADDR_STATUS) begin
            o_rdata <= {7'h00, fault_any};
        end else begin
            o_rdata <= 8'h00;
        end
    end

endmodule : charger_supervision_control

`default_nettype wire

// >>> dv/charger_supervision_properties.sv
// Assertions on the supervision block's ports.
`timescale 1ns/1ps
`default_nettype none
module charger_supervision_properties
    import charger_supervision_pkg::*;
(
    input wire logic i_mclk, i_reset_n, i_master_power_enable, i_doubler_enable_pin_n,
    input wire logic i_mode_active, i_mode_idle, i_sample_valid,
    input wire protect_t i_protect,
    input wire logic [7:0] i_sample,
    input wire reg_req_t i_req,
    input wire logic [2:0] o_channel_select,
    input wire logic o_sample_start, o_doubler_enable, o_fault_out_n, o_interrupt_out_n,
    input wire logic [7:0] o_rdata
);
    logic [7:0] low_len_q;
    logic [2:0] clr_q;
    logic [4:0] pwr_q;
    logic power_ok;
    // Fault, interrupt and channel-step checks are judged only after five powered edges.
    assign power_ok = &pwr_q;
    always_ff @(posedge i_mclk) begin
        pwr_q <= {pwr_q[3:0], i_master_power_enable};
        clr_q <= {clr_q[1:0], i_req.wr && (i_req.addr == ADDR_EVENT || i_req.addr == ADDR_MASK)};
    end
    always_ff @(posedge i_mclk) begin
        if (o_fault_out_n) begin
            low_len_q <= 8'h00;
        end else if (low_len_q != 8'hFF) begin
            low_len_q <= low_len_q + 8'h01;
        end
    end
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_reset_n);
    sequence power_off_s; !i_master_power_enable [*4]; endsequence
    sequence fault_held_s; (|i_protect[7:0]) [*4]; endsequence
    sequence no_mode_s; !(i_mode_active || i_mode_idle) [*3]; endsequence
    sequence protect_s;
        (!i_protect.vin_present || i_protect.vin_ov || i_protect.vin_uv || i_protect.vbat_ov
            || i_protect.vbat_uv || i_protect.crit_temp) [*4];
    endsequence
    power_gate_a: assert property (
        power_off_s |-> !o_doubler_enable && o_interrupt_out_n && o_rdata == 8'h00)
        else $error("outputs active while power is off");
    pin_clear_a: assert property (
        $rose(i_doubler_enable_pin_n) |-> ##[1:5] !o_doubler_enable)
        else $error("doubler not cleared by pin rise");
    fault_assert_a: assert property (fault_held_s ##0 power_ok |-> !o_fault_out_n)
        else $error("fault output not asserted");
    fault_width_a: assert property (
        $rose(o_fault_out_n) && power_ok |-> low_len_q >= FAULT_MIN_CYCLES)
        else $error("fault output pulse too short");
    irq_release_a: assert property (
        $rose(o_interrupt_out_n) && power_ok |-> clr_q != 3'h0)
        else $error("interrupt released without a clear");
    chan_step_a: assert property (
        o_channel_select != $past(o_channel_select) && o_channel_select != 3'h0 && power_ok
            |-> o_channel_select == $past(o_channel_select) + 3'h1)
        else $error("channel order broken");
    chan_range_a: assert property (o_channel_select <= LAST_CHANNEL)
        else $error("channel index out of range");
    mode_gate_a: assert property (no_mode_s |-> !o_sample_start)
        else $error("conversion in wrong mode");
    start_pulse_a: assert property (o_sample_start |=> !o_sample_start)
        else $error("sample request too long");
    protect_off_a: assert property (protect_s |-> !o_doubler_enable)
        else $error("doubler on during protection fault");
endmodule : charger_supervision_properties
bind charger_supervision_control charger_supervision_properties chk_i (.*);
`default_nettype wire

// >>> dv/converter_model.sv
// Converter front end model that answers sample requests.
`timescale 1ns/1ps
`default_nettype none
module converter_model
    import charger_supervision_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_slow,
    input wire logic [7:0] i_offset,
    input wire logic i_sample_start,
    input wire logic [2:0] i_channel,
    output logic [7:0] o_sample,
    output logic o_sample_valid
);
    logic busy_q = 1'b0;
    logic [3:0] wait_q = 4'h0;
    initial begin
        o_sample = 8'h5A;
        o_sample_valid = 1'b0;
    end
    // Data toggles outside the valid cycle so no stale value is averaged.
    always @(posedge i_mclk) begin
        o_sample_valid <= 1'b0;
        o_sample <= ~o_sample;
        if (i_sample_start) begin
            busy_q <= 1'b1;
            wait_q <= i_slow ? 4'h7 : 4'h0;
        end else if (busy_q && wait_q != 4'h0) begin
            wait_q <= wait_q - 4'h1;
        end else if (busy_q) begin
            busy_q <= 1'b0;
            o_sample_valid <= 1'b1;
            o_sample <= (i_channel == LAST_CHANNEL) ? i_offset
                : CODE_BASE + {i_channel, 5'h00} + {3'h0, i_offset[4:0]};
        end
    end
endmodule : converter_model
`default_nettype wire

// >>> dv/charger_supervision_control_tb_top.sv
// Testbench for the charger supervision block.
`timescale 1ns/1ps
`default_nettype none
module charger_supervision_control_tb_top import charger_supervision_pkg::*; ;
    logic i_mclk, i_reset_n, i_master_power_enable, i_doubler_enable_pin_n;
    logic i_mode_active, i_mode_idle, i_sample_valid, slow, rd_seen;
    logic o_sample_start, o_doubler_enable, o_fault_out_n, o_interrupt_out_n;
    logic [7:0] i_sample, ofs, o_rdata;
    logic [2:0] o_channel_select;
    logic [7:0] exp_q[$];
    protect_t i_protect;
    reg_req_t i_req;
    int err_count, compares, n;
    initial begin
        i_mclk = 1'b0;
        forever #4 i_mclk = ~i_mclk;
    end
    charger_supervision_control #(.TICK_CYCLES(4)) charger_supervision_control_i (.*);
    converter_model converter_model_i (.i_mclk(i_mclk), .i_slow(slow), .i_offset(ofs),
        .i_sample_start(o_sample_start), .i_channel(o_channel_select), .o_sample(i_sample),
        .o_sample_valid(i_sample_valid));
    task results;
        if (err_count == 0 && compares > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : results
    task check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task bus(input logic [7:0] a, input logic [7:0] d, input logic w, input logic r);
        @(posedge i_mclk);
        i_req <= '{addr: a, wdata: d, wr: w, rd: r};
    endtask : bus
    task wr(input logic [7:0] a, input logic [7:0] d);
        bus(a, d, 1'b1, 1'b0);
    endtask : wr
    task rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        bus(a, 8'h00, 1'b0, 1'b1);
    endtask : rd
    task idle(input int c);
        bus(8'h00, 8'h00, 1'b0, 1'b0);
        repeat (c) @(posedge i_mclk);
        #1;
    endtask : idle
    task wait_sweep;
        idle(0);
        n = 0;
        while (o_channel_select !== LAST_CHANNEL && n < 2000) begin @(posedge i_mclk); n++; end
        while (o_channel_select !== 3'h0 && n < 2000) begin @(posedge i_mclk); n++; end
        if (n >= 2000) begin err_count++; results(); end
        idle(4);
    endtask : wait_sweep
    task wait_doubler_off(input int lim);
        n = 0;
        while (o_doubler_enable !== 1'b0 && n < lim) begin @(posedge i_mclk); n++; end
        if (n >= lim) begin err_count++; results(); end
    endtask : wait_doubler_off
    function automatic logic [7:0] code(input logic [2:0] ch);
        return (ch == 3'h5) ? ofs : 8'h10 + {ch, 5'h00} + {3'h0, ofs[4:0]};
    endfunction : code
    task rd_results;
        for (int c = 0; c < CHANNELS; c++) rd(ADDR_RESULT_BASE + 8'(c), code(3'(c)));
    endtask : rd_results
    // Read data stand in the cycle after the read strobe.
    always @(posedge i_mclk) begin
        if (rd_seen) check(o_rdata, exp_q.pop_front());
        rd_seen <= i_req.rd;
    end
    initial begin
        {i_reset_n, i_mode_active, i_mode_idle, slow, rd_seen} = 5'h00;
        {i_master_power_enable, i_doubler_enable_pin_n} = 2'h3;
        i_protect = '0;
        i_req = '0;
        err_count = 0;
        compares = 0;
        n = $urandom(41462);
        ofs = 8'($urandom);
        repeat (4) @(posedge i_mclk);
        i_reset_n <= 1'b1;
        repeat (3) @(posedge i_mclk);
        rd(ADDR_CONV_CTRL, CONV_CTRL_RESET);
        rd(ADDR_MASK, {4'h0, MASK_RESET});
        rd(ADDR_SAFETY_RELOAD, SAFETY_RELOAD_RESET);
        rd(8'h07, 8'h00);
        rd(ADDR_EVENT, 8'h00);
        i_mode_idle <= 1'b1;
        wait_sweep();
        rd_results();
        rd(ADDR_EVENT, 8'h01);
        idle(2);
        check({7'h0, o_interrupt_out_n}, 8'h01);
        wr(ADDR_MASK, 8'h0E);
        idle(3);
        check({7'h0, o_interrupt_out_n}, 8'h00);
        wr(ADDR_EVENT, 8'h01);
        idle(3);
        check({7'h0, o_interrupt_out_n}, 8'h01);
        wait_sweep();
        rd(ADDR_EVENT, 8'h00);
        ofs <= 8'($urandom);
        slow <= 1'b1;
        wr(ADDR_CONV_CTRL, 8'h08);
        idle(400);
        wr(ADDR_CONV_CTRL, 8'h0A);
        idle(0);
        n = 0;
        repeat (600) begin @(posedge i_mclk); if (o_sample_start) n++; end
        check(8'(n), 8'h18);
        rd_results();
        rd(ADDR_EVENT, 8'h01);
        rd(ADDR_CONV_CTRL, 8'h08);
        slow <= 1'b0;
        wr(ADDR_OC_LIMIT, code(3'h2) - 8'h01);
        wr(ADDR_CONV_CTRL, 8'h01);
        wait_sweep();
        wait_sweep();
        rd(ADDR_EVENT, 8'h09);
        wr(ADDR_OC_LIMIT, 8'h00);
        wr(ADDR_EVENT, 8'h0F);
        i_protect.vin_present <= 1'b1;
        i_mode_active <= 1'b1;
        wr(ADDR_SAFETY_RELOAD, 8'h08);
        idle(4);
        i_doubler_enable_pin_n <= 1'b0;
        idle(6);
        check({7'h0, o_doubler_enable}, 8'h01);
        wait_doubler_off(60);
        rd(ADDR_EVENT, 8'h02);
        wr(ADDR_DOUBLER_CTRL, 8'h01);
        idle(3);
        check({7'h0, o_doubler_enable}, 8'h00);
        wr(ADDR_SAFETY_RELOAD, 8'hFF);
        wr(ADDR_EVENT, 8'h02);
        wr(ADDR_DOUBLER_CTRL, 8'h01);
        idle(3);
        check({7'h0, o_doubler_enable}, 8'h01);
        i_doubler_enable_pin_n <= 1'b1;
        idle(6);
        check({7'h0, o_doubler_enable}, 8'h00);
        wr(ADDR_HOST_RELOAD, 8'h06);
        wr(ADDR_DOUBLER_CTRL, 8'h01);
        for (int k = 0; k < 5; k++) begin idle(12); wr(ADDR_HOST_RELOAD, 8'h06); end
        idle(1);
        check({7'h0, o_doubler_enable}, 8'h01);
        wait_doubler_off(60);
        rd(ADDR_EVENT, 8'h04);
        rd(ADDR_HOST_VALUE, 8'h00);
        i_protect.vbat_warn <= 1'b1;
        idle(6);
        check({7'h0, o_fault_out_n}, 8'h00);
        i_protect.vbat_warn <= 1'b0;
        idle(100);
        check({7'h0, o_fault_out_n}, 8'h00);
        idle(60);
        check({7'h0, o_fault_out_n}, 8'h01);
        i_master_power_enable <= 1'b0;
        idle(8);
        i_master_power_enable <= 1'b1;
        idle(4);
        rd(ADDR_MASK, 8'h0F);
        idle(4);
        results();
    end
endmodule : charger_supervision_control_tb_top
`default_nettype wire
